// File: hw/iepo_encoder_out.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Resolution is any integer 1 to 5000; pulse counts scale to it.
// - Teach input picks one of nine fixed resolutions, 360 to 5000.
// - A preset resolution fixed at build time is loaded at reset.
// - Every millisecond sample angle and compute pulses owed for the change.
// - Pulses of one sample are emitted inside 800 us of it only up to 158; any more carry over.
// - Emitted count follows sensed angle, but motion during a burst or a settings resync, and pulses pending at a burst start, are dropped.
// - Five outputs: A, A inverted, B, B inverted, index.
// - Burst emits absolute position as pulses at a fixed 10 kHz.
// - Burst length equals single-turn distance from zero, with direction and resolution.
// - A burst starts only on a teach request.
// - Index position is a setting.
// - Direction setting chooses which rotation counts positive.
// - Tracks never switch faster than 200 kHz.
module iepo_encoder_out
  import iepo_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter logic [PPR_W-1:0] PRESET_PPR = PPR_PRESET
)(
  input wire logic clk, // 50 MHz
  input wire logic rst, // Sync, active high
  input wire logic [ANG_W-1:0] angle, // Absolute angle, full turn = 2^16
  input wire logic teach_burst, // Teach burst request pulse
  input wire logic teach_set, // Teach resolution pulse
  input wire logic [3:0] teach_sel, // Teach resolution choice 0..8
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic trk_a, // Track A
  output logic trk_a_n, // Track A inverted
  output logic trk_b, // Track B
  output logic trk_b_n, // Track B inverted
  output logic trk_z // Index track
);
  localparam int STW = TMR_W + 6;
  iepo_state_type state;
  logic counting_direction_select;
  logic [PPR_W-1:0] ppr;
  logic [PPR_W-1:0] index_pos;
  logic [ANG_W-1:0] angle_smp;
  logic [STW-1:0] smp_cnt;
  logic smp_tick;
  logic resync;
  logic [PPR_W-1:0] prev_pos;
  logic signed [PEND_W-1:0] pending;
  logic [PEND_W-1:0] burst_left;
  logic [TMR_W-1:0] step_cnt;
  logic [1:0] phase;
  logic [PPR_W-1:0] pulse_pos;
  logic [ANG_W-1:0] dir_angle;
  logic [ANG_W+PPR_W-1:0] product;
  logic [PPR_W-1:0] scaled;
  logic signed [PPR_W+1:0] delta;
  logic step_fwd;
  logic step_bwd;
  logic step_now;
  logic apb_wr;
  logic apb_rd;
  logic [PPR_W-1:0] ppr_clamped;

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == REG_CTRL) || (a == REG_PPR) || (a == REG_INDEX) ||
                 (a == REG_STATUS) || (a == REG_POS) || (a == REG_ANGLE);
  endfunction

  // Zero-angle stays zero when the counting sense is reversed
  always_comb
  begin
    dir_angle = counting_direction_select ? ANG_W'(0 - angle) : angle;
    product = (ANG_W+PPR_W)'(dir_angle) * (ANG_W+PPR_W)'(ppr);
    scaled = product[ANG_W+PPR_W-1:ANG_W];
    delta = (PPR_W+2)'(scaled) - (PPR_W+2)'(prev_pos);
    // Shortest way round the turn; compared signed, or a backward move reads as huge
    if (delta > $signed((PPR_W+2)'(ppr >> 1)))
      delta = delta - $signed((PPR_W+2)'(ppr));
    else if (delta < -$signed((PPR_W+2)'(ppr >> 1)))
      delta = delta + $signed((PPR_W+2)'(ppr));
  end

  always_comb
  begin
    ppr_clamped = pwdata[PPR_W-1:0];
    if (pwdata[31:PPR_W] != '0 || pwdata[PPR_W-1:0] > PPR_MAX)
      ppr_clamped = PPR_MAX;
    else if (pwdata[PPR_W-1:0] < PPR_MIN)
      ppr_clamped = PPR_MIN;
  end

  assign apb_wr = psel && penable && pwrite && !pready;
  assign apb_rd = psel && penable && !pwrite && !pready;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !reg_mapped(paddr);
      prdata <= '0;
      if (apb_rd)
      begin
        case (paddr)
          REG_CTRL: prdata[CTRL_DIR_BIT] <= counting_direction_select;
          REG_PPR: prdata[PPR_W-1:0] <= ppr;
          REG_INDEX: prdata[PPR_W-1:0] <= index_pos;
          REG_STATUS:
          begin
            prdata[STAT_BURST_BIT] <= (state != IEPO_ST_TRACK);
            prdata[STAT_PEND_BIT] <= (pending != '0);
          end
          REG_POS: prdata[PPR_W-1:0] <= pulse_pos;
          REG_ANGLE: prdata[ANG_W-1:0] <= angle_smp;
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Settings; a change of scale or sense forces a fresh reference sample
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ppr <= PRESET_PPR;
      counting_direction_select <= 1'b0;
      index_pos <= '0;
      resync <= 1'b1;
    end
    else
    begin
      if (smp_tick)
        resync <= 1'b0;
      if (teach_set && teach_sel < 4'(TEACH_N) && state == IEPO_ST_TRACK)
      begin
        ppr <= iepo_teach_ppr(teach_sel);
        resync <= 1'b1;
      end
      else if (apb_wr && paddr == REG_PPR)
      begin
        ppr <= ppr_clamped;
        resync <= 1'b1;
      end
      else if (apb_wr && paddr == REG_CTRL)
      begin
        counting_direction_select <= pwdata[CTRL_DIR_BIT];
        resync <= 1'b1;
      end
      else if (apb_wr && paddr == REG_INDEX)
        index_pos <= (pwdata[PPR_W-1:0] < ppr) ? pwdata[PPR_W-1:0] : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      smp_cnt <= '0;
      smp_tick <= 1'b0;
      angle_smp <= '0;
    end
    else
    begin
      smp_tick <= (smp_cnt == STW'(SAMPLE_CYCLES - 1));
      smp_cnt <= (smp_cnt == STW'(SAMPLE_CYCLES - 1)) ? '0 : smp_cnt + 1'b1;
      if (smp_cnt == STW'(SAMPLE_CYCLES - 1))
        angle_smp <= angle;
    end
  end

  assign step_now = (step_cnt == '0);
  assign step_fwd = step_now && (state == IEPO_ST_BURST ? burst_left != '0 :
                    state == IEPO_ST_TRACK && pending > 0);
  assign step_bwd = step_now && state == IEPO_ST_TRACK && pending < 0;

  // Work is counted in quarter steps, so a reversal mid-pulse stays exact
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= IEPO_ST_TRACK;
      pending <= '0;
      burst_left <= '0;
      prev_pos <= '0;
    end
    else
    begin
      case (state)
        IEPO_ST_TRACK:
        begin
          if (teach_burst)
          begin
            state <= IEPO_ST_BURST;
            burst_left <= PEND_W'(scaled) << 2;
            pending <= '0;
            prev_pos <= scaled;
          end
          else
          begin
            if (smp_tick)
              prev_pos <= scaled;
            pending <= pending + (smp_tick && !resync ? PEND_W'(delta) <<< 2 : '0)
                       - (step_fwd ? PEND_W'(1) : '0) + (step_bwd ? PEND_W'(1) : '0);
          end
        end
        IEPO_ST_BURST:
        begin
          if (step_fwd)
            burst_left <= burst_left - 1'b1;
          if (burst_left == '0)
            state <= IEPO_ST_DRAIN;
        end
        IEPO_ST_DRAIN:
        begin
          // Take a fresh reference, so motion made during the burst is dropped, not emitted
          if (smp_tick)
          begin
            prev_pos <= scaled;
            state <= IEPO_ST_TRACK;
          end
        end
        default: state <= IEPO_ST_TRACK;
      endcase
    end
  end

  // Fastest rate, 63 cycles a quarter step: 158 pulses fit in the 800 us window; more carry over
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      step_cnt <= '0;
      phase <= '0;
      pulse_pos <= '0;
    end
    else
    begin
      if (step_fwd || step_bwd)
      begin
        step_cnt <= (state == IEPO_ST_BURST) ? TMR_W'(BURST_STEP_CYC - 1) :
                    TMR_W'(STEP_MIN_CYC - 1);
      end
      else if (!step_now)
        step_cnt <= step_cnt - 1'b1;
      if (state == IEPO_ST_TRACK && teach_burst)
        pulse_pos <= '0;
      else if (step_fwd)
      begin
        phase <= phase + 1'b1;
        if (phase == 2'h3)
          pulse_pos <= (pulse_pos >= ppr - 1'b1) ? '0 : pulse_pos + 1'b1;
      end
      else if (step_bwd)
      begin
        phase <= phase - 1'b1;
        if (phase == 2'h0)
          pulse_pos <= (pulse_pos == '0) ? ppr - 1'b1 : pulse_pos - 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trk_a <= 1'b0;
      trk_a_n <= 1'b1;
      trk_b <= 1'b0;
      trk_b_n <= 1'b1;
      trk_z <= 1'b0;
    end
    else
    begin
      trk_a <= phase[1];
      trk_a_n <= !phase[1];
      trk_b <= phase[1] ^ phase[0];
      trk_b_n <= !(phase[1] ^ phase[0]);
      trk_z <= (pulse_pos == index_pos) && (phase == 2'h0);
    end
  end

  localparam int GAP_MIN = STEP_MIN_CYC;
  localparam int GAP_BURST = BURST_STEP_CYC;
  logic [TMR_W-1:0] edge_gap;
  logic [STW-1:0] tick_gap;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      edge_gap <= '1;
      tick_gap <= '1; // Wraps to zero on the first free edge, matching the sample counter
    end
    else
    begin
      edge_gap <= (trk_a != phase[1] || trk_b != (phase[1] ^ phase[0])) ? '0 :
                  (edge_gap == '1 ? edge_gap : edge_gap + 1'b1);
      tick_gap <= smp_tick ? '0 : tick_gap + 1'b1;
    end
  end

  sequence burst_req_s;
    state == IEPO_ST_TRACK && teach_burst;
  endsequence
  sequence burst_run_s;
    state == IEPO_ST_BURST;
  endsequence

  chk_comp_tracks: assert property (@(posedge clk) disable iff (rst)
    trk_a_n == !trk_a && trk_b_n == !trk_b)
    else $error("inverted track is not the complement");
  chk_quad_single: assert property (@(posedge clk) disable iff (rst)
    !($changed(trk_a) && $changed(trk_b)))
    else $error("both tracks switched together");
  chk_step_gap: assert property (@(posedge clk) disable iff (rst)
    (trk_a != phase[1] || trk_b != (phase[1] ^ phase[0])) |-> edge_gap >= TMR_W'(GAP_MIN - 1))
    else $error("track edges closer than the switching limit");
  chk_burst_gap: assert property (@(posedge clk) disable iff (rst)
    (state == IEPO_ST_BURST && step_fwd) |=> !step_fwd [*8])
    else $error("burst steps too close");
  chk_burst_period: assert property (@(posedge clk) disable iff (rst)
    (state == IEPO_ST_BURST && step_fwd) |-> ##1 step_cnt == TMR_W'(GAP_BURST - 1))
    else $error("burst step period wrong");
  chk_burst_start: assert property (@(posedge clk) disable iff (rst)
    $rose(state == IEPO_ST_BURST) |-> $past(teach_burst))
    else $error("burst started without a teach request");
  chk_burst_len: assert property (@(posedge clk) disable iff (rst)
    burst_req_s |=> burst_run_s ##0 burst_left == PEND_W'($past(scaled)) << 2)
    else $error("burst length not equal to position");
  chk_ppr_range: assert property (@(posedge clk) disable iff (rst)
    ppr >= PPR_MIN && ppr <= PPR_MAX)
    else $error("resolution out of range");
  chk_teach_sel: assert property (@(posedge clk) disable iff (rst)
    (teach_set && teach_sel < 4'(TEACH_N) && state == IEPO_ST_TRACK)
    |=> ppr == iepo_teach_ppr($past(teach_sel)))
    else $error("teach resolution not applied");
  chk_sample_tick: assert property (@(posedge clk) disable iff (rst)
    smp_tick |-> tick_gap == STW'(SAMPLE_CYCLES - 1))
    else $error("sample period wrong");
  chk_index_pos: assert property (@(posedge clk) disable iff (rst)
    $rose(trk_z) |-> $past(pulse_pos) == $past(index_pos))
    else $error("index pulse at wrong position");
endmodule
`default_nettype wire

// File: hw/iepo_pkg.sv
package iepo_pkg;
  localparam int CLK_MHZ = 50;
  localparam int SAMPLE_US = 1000;
  localparam int BURST_WIN_US = 800;
  localparam int MAX_SW_KHZ = 200;
  localparam int BURST_KHZ = 10;
  localparam int STEPS_PER_PULSE = 4;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int BURST_WIN_CYC = BURST_WIN_US * CLK_MHZ;
  // Least quarter-step spacing, rounded up
  localparam int STEP_MIN_CYC = (CLK_MHZ * 1000 + MAX_SW_KHZ * STEPS_PER_PULSE - 1)
                                / (MAX_SW_KHZ * STEPS_PER_PULSE);
  localparam int BURST_STEP_CYC = (CLK_MHZ * 1000) / (BURST_KHZ * STEPS_PER_PULSE);

  localparam int ANG_W = 16;
  localparam int PPR_W = 13;
  localparam int PEND_W = 20;
  localparam int TMR_W = 12;
  localparam logic [PPR_W-1:0] PPR_MIN = 13'h0001;
  localparam logic [PPR_W-1:0] PPR_MAX = 13'h1388;
  localparam logic [PPR_W-1:0] PPR_PRESET = 13'h0400;
  localparam int TEACH_N = 9;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PPR = 8'h04;
  localparam logic [7:0] REG_INDEX = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_POS = 8'h10;
  localparam logic [7:0] REG_ANGLE = 8'h14;
  localparam int CTRL_DIR_BIT = 0;
  localparam int STAT_BURST_BIT = 0;
  localparam int STAT_PEND_BIT = 1;

  typedef enum logic [2:0] {
    IEPO_ST_TRACK = 3'b001,
    IEPO_ST_BURST = 3'b010,
    IEPO_ST_DRAIN = 3'b100
  } iepo_state_type;

  function automatic logic [PPR_W-1:0] iepo_teach_ppr(input logic [3:0] sel);
    case (sel)
      4'h0: iepo_teach_ppr = 13'h0168;
      4'h1: iepo_teach_ppr = 13'h0200;
      4'h2: iepo_teach_ppr = 13'h03e8;
      4'h3: iepo_teach_ppr = 13'h0400;
      4'h4: iepo_teach_ppr = 13'h0800;
      4'h5: iepo_teach_ppr = 13'h09c4;
      4'h6: iepo_teach_ppr = 13'h0e10;
      4'h7: iepo_teach_ppr = 13'h1000;
      default: iepo_teach_ppr = 13'h1388;
    endcase
  endfunction
endpackage

// File: tb/iepo_counter_card.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side counter card: decodes every quarter step, no input filtering
module iepo_counter_card
  import iepo_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic rst, // Sync reset, active high
  input wire logic a, // Track A
  input wire logic a_n, // Track A inverted
  input wire logic b, // Track B
  input wire logic b_n, // Track B inverted
  input wire logic z, // Index track
  output var int qcnt, // Signed quarter step count
  output var int zcnt, // Index pulses seen
  output var int errs, // Line faults seen
  output var int gap // Cycles between the last two steps
);
  logic [1:0] prev;
  logic [1:0] now;
  logic z_q;
  logic moved;
  logic bad_inv;
  logic bad_step;
  logic bad_fast;
  int run;

  // Gray phase to binary, so a forward step is always plus one
  assign now = {a, a ^ b};
  assign moved = now != prev;
  assign bad_inv = (a_n !== ~a) || (b_n !== ~b);
  assign bad_step = moved && ((now - prev) == 2'd2);
  assign bad_fast = moved && (run < STEP_MIN_CYC);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev <= 2'b00;
      z_q <= 1'b0;
      run <= 0;
      qcnt <= 0;
      zcnt <= 0;
      errs <= 0;
      gap <= 0;
    end
    else
    begin
      z_q <= z;
      run <= moved ? 1 : run + 1;
      errs <= errs + int'(bad_inv) + int'(bad_step) + int'(bad_fast);
      if (z && !z_q)
        zcnt <= zcnt + 1;
      if (moved)
      begin
        prev <= now;
        gap <= run;
        if ((now - prev) == 2'd1)
          qcnt <= qcnt + 1;
        else if ((now - prev) == 2'd3)
          qcnt <= qcnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/iepo_encoder_out_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module iepo_encoder_out_tb_top;
  import iepo_pkg::*;
  // Short sample period keeps the run small; the sample waits and the watchdog derive from it
  localparam int SC = 1000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ANG_W-1:0] angle = '0;
  logic teach_burst = 1'b0;
  logic teach_set = 1'b0;
  logic [3:0] teach_sel = 4'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, trk_a, trk_a_n, trk_b, trk_b_n, trk_z;
  logic [31:0] rd;
  logic err;
  int qcnt, zcnt, errs, gap;
  int fails = 0;
  int n_checks = 0;
  int tbl[9] = '{360, 512, 1000, 1024, 2048, 2500, 3600, 4096, 5000};

  always #10 clk = ~clk;

  iepo_encoder_out #(.SAMPLE_CYCLES(SC), .PRESET_PPR(PPR_PRESET)) dut (
    .clk(clk), .rst(rst), .angle(angle), .teach_burst(teach_burst),
    .teach_set(teach_set), .teach_sel(teach_sel), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trk_a(trk_a), .trk_a_n(trk_a_n),
    .trk_b(trk_b), .trk_b_n(trk_b_n), .trk_z(trk_z));

  iepo_counter_card card (
    .clk(clk), .rst(rst), .a(trk_a), .a_n(trk_a_n), .b(trk_b), .b_n(trk_b_n),
    .z(trk_z), .qcnt(qcnt), .zcnt(zcnt), .errs(errs), .gap(gap));

  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      cmp("apb ready", 1, 0);
  endtask

  task automatic ticks(input int n);
    repeat (n * SC) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic teach(input logic burst);
    @(posedge clk);
    teach_burst <= burst;
    teach_set <= !burst;
    @(posedge clk);
    teach_burst <= 1'b0;
    teach_set <= 1'b0;
  endtask

  function automatic int pos(input int ang, input int ppr);
    return (ang * ppr) >>> 16;
  endfunction

  // Shortest-way pulse change between two angles
  function automatic int moved(input int a0, input int a1, input int ppr);
    int d;
    d = pos(a1, ppr) - pos(a0, ppr);
    if (2 * d > ppr)
      d = d - ppr;
    else if (2 * d < -ppr)
      d = d + ppr;
    return d;
  endfunction

  initial
  begin
    repeat (90 * SC) @(posedge clk);
    cmp("watchdog", 0, 1);
    stop_test();
  end

  initial
  begin
    int ppr, a0, a1, q0, span, exp_q;
    q0 = $urandom(16799);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp("tracks", 32'h0000_0005, {28'h0, trk_a, trk_a_n, trk_b, trk_b_n});
    apb(1'b0, REG_PPR, 0);
    cmp("ppr reset", 32'h0000_0400, rd);
    apb(1'b0, 8'h20, 0);
    cmp("unmapped", 1, {31'h0, err});
    apb(1'b1, REG_PPR, 0);
    apb(1'b0, REG_PPR, 0);
    cmp("ppr low", 1, rd);
    apb(1'b1, REG_PPR, 32'h0000_1770);
    apb(1'b0, REG_PPR, 0);
    cmp("ppr high", 32'h0000_1388, rd);
    for (int i = 0; i < 9; i++)
    begin
      teach_sel <= i[3:0];
      teach(1'b0);
      apb(1'b0, REG_PPR, 0);
      cmp("teach ppr", tbl[i], rd);
    end
    $display("test settings done");
    for (int dir = 0; dir < 2; dir++)
    begin
      ppr = 1 + $urandom % 5000;
      apb(1'b1, REG_PPR, ppr);
      apb(1'b1, REG_CTRL, dir);
      a0 = 'hff00;
      angle <= 16'hff00;
      ticks(3);
      span = (196608 / ppr > 2000) ? 2000 : 196608 / ppr;
      for (int k = 0; k < 4; k++)
      begin
        a1 = (a0 + $urandom % (2 * span + 1) - span) & 'hffff;
        q0 = qcnt;
        @(posedge clk);
        angle <= a1[15:0];
        ticks(3);
        exp_q = dir ? moved(-a0 & 'hffff, -a1 & 'hffff, ppr) : moved(a0, a1, ppr);
        cmp("steps", 4 * exp_q, qcnt - q0);
        a0 = a1;
      end
    end
    $display("test tracking done");
    apb(1'b1, REG_PPR, 16);
    apb(1'b1, REG_CTRL, 0);
    apb(1'b1, REG_INDEX, 20);
    apb(1'b0, REG_INDEX, 0);
    cmp("index refused", 0, rd);
    apb(1'b1, REG_INDEX, 5);
    apb(1'b0, REG_INDEX, 0);
    cmp("index set", 5, rd);
    angle <= 16'h0000;
    ticks(3);
    q0 = zcnt;
    for (int k = 1; k <= 8; k++)
    begin
      @(posedge clk);
      angle <= 16'(k * 16'h2000);
      ticks(2);
    end
    cmp("index count", 1, zcnt - q0);
    $display("test index done");
    @(posedge clk);
    angle <= 16'h3000;
    ticks(3);
    q0 = qcnt;
    teach(1'b1);
    repeat (12 * BURST_STEP_CYC + 3 * SC) @(posedge clk);
    @(negedge clk);
    cmp("burst steps", 12, qcnt - q0);
    cmp("burst rate", BURST_STEP_CYC, gap);
    cmp("line faults", 0, errs);
    apb(1'b0, REG_POS, 0);
    cmp("burst pos", pos(32'h0000_3000, 16), rd);
    apb(1'b0, REG_ANGLE, 0);
    cmp("sampled angle", 32'h0000_3000, rd);
    $display("test burst done");
    stop_test();
  end
endmodule
`default_nettype wire
